// File: rtl/lpw_defines.vh
// constants of the two-stage watchdog timer
`ifndef LPW_DEFINES_VH
`define LPW_DEFINES_VH
// byte port indexes; the bus address is four times the index
`define LPW_IDX_CNT0    4'h0
`define LPW_IDX_CNT1    4'h1
`define LPW_IDX_CNT2    4'h2
`define LPW_IDX_RLD0    4'h3
`define LPW_IDX_RLD1    4'h4
`define LPW_IDX_RLD2    4'h5
`define LPW_IDX_STATUS  4'h6
`define LPW_IDX_CONTROL 4'h7
`define LPW_IDX_CONFIG  4'h8
`define LPW_IDX_MASK    4'h9
// field positions
`define LPW_ST_FIRST    0
`define LPW_ST_SECOND   2
`define LPW_CT_RESET    0
`define LPW_CT_DECR     1
`define LPW_CF_ENABLE   0
`define LPW_CF_PORT80   1
`define LPW_CF_SEL_LO   4
`define LPW_CF_SEL_HI   7
// reset values
`define LPW_RST_BYTE    8'h00
`define LPW_RST_CNT     24'h000000
// time base
`define LPW_CLK_HZ      100000000
`define LPW_TICK_HZ     32768
// axi responses
`define LPW_RESP_OKAY   2'b00
`define LPW_RESP_SLVERR 2'b10
`endif

// File: rtl/lpw_watchdog.v
// two-stage watchdog timer with axi4-lite register port
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`include "lpw_defines.vh"
`default_nettype none
module lpw_watchdog #(
  parameter IRQ_LINES = 16,
  parameter CLK_HZ    = `LPW_CLK_HZ,
  parameter TICK_HZ   = `LPW_TICK_HZ
) (
  input  wire                 aclk,
  input  wire                 aresetn,
  input  wire [5:0]           s_axi_awaddr,
  input  wire                 s_axi_awvalid,
  output wire                 s_axi_awready,
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  input  wire                 s_axi_wvalid,
  output wire                 s_axi_wready,
  output wire [1:0]           s_axi_bresp,
  output wire                 s_axi_bvalid,
  input  wire                 s_axi_bready,
  input  wire [5:0]           s_axi_araddr,
  input  wire                 s_axi_arvalid,
  output wire                 s_axi_arready,
  output wire [31:0]          s_axi_rdata,
  output wire [1:0]           s_axi_rresp,
  output wire                 s_axi_rvalid,
  input  wire                 s_axi_rready,
  input  wire                 port80_write,
  output wire                 irq,
  output wire [IRQ_LINES-1:0] irq_lines,
  output wire                 board_reset
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  reg        awready_q, wready_q, arready_q, bvalid_q, rvalid_q;
  reg        aw_have_q, w_have_q;
  reg [3:0]  aw_idx_q;
  reg [7:0]  wbyte_q;
  reg        wstb_q;
  reg [1:0]  bresp_q, rresp_q;
  reg [31:0] rdata_q;
  reg [23:0] cnt_q, rld_q;
  reg [7:0]  status_q, control_q, config_q, mask_q;
  reg        armed_q;
  reg [27:0] acc_q;
  reg        irq_q, board_reset_q;
  reg [IRQ_LINES-1:0] irq_lines_q;

  ////////////////////////////////////////////////////////////////////////////
  // write channel handshake: address and data taken in either order
  wire       aw_take  = s_axi_awvalid & awready_q;
  wire       w_take   = s_axi_wvalid & wready_q;
  wire       wr_go    = aw_have_q & w_have_q & ~bvalid_q;
  wire       aw_have_d = (aw_have_q & ~wr_go) | aw_take;
  wire       w_have_d  = (w_have_q & ~wr_go) | w_take;
  wire       wr_map   = (aw_idx_q <= `LPW_IDX_MASK);
  wire       wr_en    = wr_go & wstb_q & wr_map;
  wire       ar_take  = s_axi_arvalid & arready_q;
  wire [3:0] ar_idx   = s_axi_araddr[5:2];

  // decoded register writes
  wire wr_cnt  = wr_en & (aw_idx_q <= `LPW_IDX_CNT2);
  wire wr_st   = wr_en & (aw_idx_q == `LPW_IDX_STATUS);
  wire wr_ct   = wr_en & (aw_idx_q == `LPW_IDX_CONTROL);
  wire wr_cf   = wr_en & (aw_idx_q == `LPW_IDX_CONFIG);
  wire wr_mk   = wr_en & (aw_idx_q == `LPW_IDX_MASK);

  ////////////////////////////////////////////////////////////////////////////
  // time base and expiry decisions
  wire [27:0] acc_sum = acc_q + TICK_HZ[27:0];
  wire        tick    = (acc_sum >= CLK_HZ[27:0]);
  wire        wd_on   = config_q[`LPW_CF_ENABLE];
  wire        p80_rld = port80_write & config_q[`LPW_CF_PORT80] & wd_on;
  wire        reload  = wr_cnt | p80_rld;
  wire        counting = wd_on & control_q[`LPW_CT_DECR] & tick;
  wire        expire  = counting & (cnt_q <= 24'h000001);
  wire        exp1    = expire & ~armed_q & ~reload;
  wire        exp2    = expire & armed_q & ~reload;
  wire [7:0]  set_st  = ({7'h00, exp1} << `LPW_ST_FIRST) | ({7'h00, exp2} << `LPW_ST_SECOND);
  wire [7:0]  clr_st  = (wr_st ? wbyte_q : 8'h00)
                      | ({7'h00, p80_rld} << `LPW_ST_FIRST);
  wire [7:0]  st_live = (8'h01 << `LPW_ST_FIRST) | (8'h01 << `LPW_ST_SECOND);
  wire [7:0]  status_d = ((status_q & ~clr_st) | set_st) & st_live;
  wire [3:0]  sel     = config_q[`LPW_CF_SEL_HI:`LPW_CF_SEL_LO];
  // one-hot image of the selected line, sized to the line count
  wire [IRQ_LINES-1:0] line_hot = {{(IRQ_LINES-1){1'b0}}, 1'b1} << sel;
  wire        irq_d   = |(status_d & mask_q) & wd_on;

  ////////////////////////////////////////////////////////////////////////////
  // read data mux, byte per word, upper bits zero
  reg [7:0] rd_byte;
  reg       rd_ok;
  always @*
  begin
    rd_byte = 8'h00;
    rd_ok   = 1'b1;
    case (ar_idx)
      `LPW_IDX_CNT0:    rd_byte = cnt_q[7:0];
      `LPW_IDX_CNT1:    rd_byte = cnt_q[15:8];
      `LPW_IDX_CNT2:    rd_byte = cnt_q[23:16];
      `LPW_IDX_RLD0:    rd_byte = rld_q[7:0];
      `LPW_IDX_RLD1:    rd_byte = rld_q[15:8];
      `LPW_IDX_RLD2:    rd_byte = rld_q[23:16];
      `LPW_IDX_STATUS:  rd_byte = status_q;
      `LPW_IDX_CONTROL: rd_byte = control_q;
      `LPW_IDX_CONFIG:  rd_byte = config_q;
      `LPW_IDX_MASK:    rd_byte = mask_q;
      default:          rd_ok   = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus slave registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_q <= 1'b1;
      wready_q  <= 1'b1;
      arready_q <= 1'b1;
      bvalid_q  <= 1'b0;
      rvalid_q  <= 1'b0;
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_idx_q  <= 4'h0;
      wbyte_q   <= `LPW_RST_BYTE;
      wstb_q    <= 1'b0;
      bresp_q   <= `LPW_RESP_OKAY;
      rresp_q   <= `LPW_RESP_OKAY;
      rdata_q   <= 32'h00000000;
    end
    else
    begin
      aw_have_q <= aw_have_d;
      w_have_q  <= w_have_d;
      awready_q <= ~aw_have_d;
      wready_q  <= ~w_have_d;
      if (aw_take)
        aw_idx_q <= s_axi_awaddr[5:2];
      if (w_take)
      begin
        wbyte_q <= s_axi_wdata[7:0];
        wstb_q  <= s_axi_wstrb[0];
      end
      // response after both halves are held
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q  <= wr_map ? `LPW_RESP_OKAY : `LPW_RESP_SLVERR;
      end
      else if (s_axi_bready)
        bvalid_q <= 1'b0;
      // read answered one cycle after the address is taken
      if (ar_take)
      begin
        arready_q <= 1'b0;
        rvalid_q  <= 1'b1;
        rdata_q   <= {24'h000000, rd_byte};
        rresp_q   <= rd_ok ? `LPW_RESP_OKAY : `LPW_RESP_SLVERR;
      end
      else if (rvalid_q & s_axi_rready)
      begin
        rvalid_q  <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration and control bytes
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      control_q <= `LPW_RST_BYTE;
      config_q  <= `LPW_RST_BYTE;
      mask_q    <= `LPW_RST_BYTE;
      rld_q     <= `LPW_RST_CNT;
      status_q  <= `LPW_RST_BYTE;
    end
    else
    begin
      if (wr_ct)
        control_q <= wbyte_q & 8'h03;
      if (wr_cf)
        config_q <= wbyte_q & 8'hf3;
      if (wr_mk)
        mask_q <= wbyte_q & st_live;
      if (wr_en & (aw_idx_q == `LPW_IDX_RLD0))
        rld_q[7:0] <= wbyte_q;
      if (wr_en & (aw_idx_q == `LPW_IDX_RLD1))
        rld_q[15:8] <= wbyte_q;
      if (wr_en & (aw_idx_q == `LPW_IDX_RLD2))
        rld_q[23:16] <= wbyte_q;
      status_q <= status_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter, tick accumulator and expiry stage
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q   <= `LPW_RST_CNT;
      armed_q <= 1'b0;
      acc_q   <= 28'h0000000;
    end
    else
    begin
      acc_q <= tick ? acc_sum - CLK_HZ[27:0] : acc_sum;
      if (reload)
      begin
        cnt_q   <= rld_q;
        armed_q <= 1'b0;
      end
      else if (expire)
      begin
        cnt_q   <= rld_q;
        armed_q <= 1'b1;
      end
      else if (counting)
        cnt_q <= cnt_q - 24'h000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt line routing and board reset
  genvar gi;
  generate
    for (gi = 0; gi < IRQ_LINES; gi = gi + 1)
    begin : g_line
      always @(posedge aclk)
      begin
        if (!aresetn)
          irq_lines_q[gi] <= 1'b0;
        else
          irq_lines_q[gi] <= irq_d & line_hot[gi];
      end
    end
  endgenerate

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_q         <= 1'b0;
      board_reset_q <= 1'b0;
    end
    else
    begin
      irq_q         <= irq_d;
      board_reset_q <= exp2 & control_q[`LPW_CT_RESET];
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign irq           = irq_q;
  assign irq_lines     = irq_lines_q;
  assign board_reset   = board_reset_q;

endmodule
`default_nettype wire

// File: tb/lpw_watchdog_checker.sv
// port assertions of the two-stage watchdog
`default_nettype none
module lpw_watchdog_checker #(
  parameter IRQ_LINES = 16
) (
  input wire logic                 aclk,
  input wire logic                 aresetn,
  input wire logic                 s_axi_awvalid,
  input wire logic                 s_axi_awready,
  input wire logic                 s_axi_wvalid,
  input wire logic                 s_axi_wready,
  input wire logic [1:0]           s_axi_bresp,
  input wire logic                 s_axi_bvalid,
  input wire logic                 s_axi_bready,
  input wire logic                 s_axi_arvalid,
  input wire logic                 s_axi_arready,
  input wire logic [31:0]          s_axi_rdata,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_rready,
  input wire logic                 irq,
  input wire logic [IRQ_LINES-1:0] irq_lines,
  input wire logic                 board_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // transfers start when both halves are taken
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence s_rtake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  property p_idle; $rose(aresetn) |-> !irq && !board_reset; endproperty
  property p_wans; s_wtake |-> ##[1:2] s_axi_bvalid; endproperty
  property p_rans; s_rtake |=> s_axi_rvalid; endproperty
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  property p_rbyte; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  property p_arbusy; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_pulse; board_reset |=> !board_reset; endproperty
  property p_line; $onehot0(irq_lines) && (irq == (irq_lines != 0)); endproperty
  // each check reports one plain line
  a_idle: assert property (p_idle) else $error("active after reset");
  a_wans: assert property (p_wans) else $error("no write answer");
  a_rans: assert property (p_rans) else $error("no read answer");
  a_bhold: assert property (p_bhold) else $error("write answer dropped");
  a_rhold: assert property (p_rhold) else $error("read answer dropped");
  a_rbyte: assert property (p_rbyte) else $error("read wider than byte");
  a_arbusy: assert property (p_arbusy) else $error("read taken while busy");
  a_pulse: assert property (p_pulse) else $error("board reset too long");
  a_line: assert property (p_line) else $error("irq line mismatch");
endmodule
bind lpw_watchdog lpw_watchdog_checker #(.IRQ_LINES(IRQ_LINES)) u_chk (.*);
`default_nettype wire

// File: tb/lpw_port80_host.sv
// host side that broadcasts port 80h write cycles
`default_nettype none
module lpw_port80_host (
  input  wire logic aclk,
  input  wire logic go,
  output var  logic port80_write
);
  timeunit 1ns;
  timeprecision 1ns;
  // one strobe per requested port 80h write
  always @(posedge aclk)
    port80_write <= go;
endmodule
`default_nettype wire

// File: tb/lpw_watchdog_test.sv
// bench of the two-stage watchdog
`default_nettype none
module lpw_watchdog_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] RV = 24'h123456;
  logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0, go = 0;
  logic [5:0]  awa = 0, ara = 0;
  logic [31:0] wd = 0;
  wire         awr, wrdy, bv, arr, rv, p80w, irq, brst;
  wire  [1:0]  br, rr;
  wire  [31:0] rd;
  wire  [15:0] lines;
  int          err_count, total_checks, cyc, nbr, t1;
  // tick every four clocks keeps timeouts short
  lpw_watchdog #(.TICK_HZ(25000000)) DUT (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1), .s_axi_wvalid(wv),
    .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rready), .port80_write(p80w),
    .irq(irq), .irq_lines(lines), .board_reset(brst));
  lpw_port80_host HOST (.aclk(aclk), .go(go), .port80_write(p80w));
  ////////////////////////////////////////
  initial
    forever #5 aclk = ~aclk;
  // cycle count, reset pulses and hang limit
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (brst === 1'b1)
      nbr <= nbr + 1;
    if (cyc == 5000)
    begin
      err_count++;
      wrap_up;
    end
  end
  task chk(input [15:0] g, input [15:0] e);
    begin
      total_checks++;
      if (g !== e)
      begin
        err_count++;
        $display("mismatch at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task wr(input [3:0] i, input [7:0] d);
    logic a, w;
    begin
      @(posedge aclk);
      awa <= {i, 2'b00};
      wd <= {24'h0, d};
      awv <= 1;
      wv <= 1;
      a = 0;
      w = 0;
      while (!(a && w))
      begin
        @(negedge aclk);
        a = a | awr;
        w = w | wrdy;
        @(posedge aclk);
        if (a) awv <= 0;
        if (w) wv <= 0;
      end
      @(posedge aclk);
      bready <= 1;
      do @(negedge aclk); while (bv !== 1);
      chk(br, 0);
      @(posedge aclk);
      bready <= 0;
    end
  endtask
  task rc(input [3:0] i, input [7:0] e, input [1:0] er = 2'b00);
    logic a;
    begin
      @(posedge aclk);
      ara <= {i, 2'b00};
      arv <= 1;
      do
      begin
        @(negedge aclk);
        a = arr;
        @(posedge aclk);
      end while (!a);
      arv <= 0;
      @(posedge aclk);
      rready <= 1;
      do @(negedge aclk); while (rv !== 1);
      chk(rd[7:0], e);
      chk(rr, er);
      @(posedge aclk);
      rready <= 0;
    end
  endtask
  task p80;
    begin
      @(posedge aclk);
      go <= 1;
      @(posedge aclk);
      go <= 0;
    end
  endtask
  // reload value low byte first, then reload the counter
  task prog(input [23:0] v);
    begin
      for (int k = 0; k < 3; k++)
        wr(4'(k + 3), v[8*k+:8]);
      wr(4'h1, 8'hff);
    end
  endtask
  task wrap_up;
    begin
      if (err_count == 0 && total_checks > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  // main sequence
  initial
  begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rc(4'h0, 8'h00);
    rc(4'h7, 8'h00);
    rc(4'ha, 8'h00, 2'b10);
    wr(4'h7, 8'h00);
    prog(RV);
    for (int k = 0; k < 3; k++)
    begin
      rc(4'(k), RV[8*k+:8]);
      rc(4'(k + 3), RV[8*k+:8]);
    end
    prog(24'h000008);
    wr(4'h8, 8'h53);
    wr(4'h9, 8'h05);
    wr(4'h7, 8'h03);
    repeat (6)
    begin
      p80;
      repeat (8) @(posedge aclk);
    end
    @(negedge aclk);
    chk(irq, 0);
    while (irq !== 1) @(negedge aclk);
    t1 = cyc;
    chk(16'(nbr), 0);
    chk(lines, 16'h0020);
    rc(4'h6, 8'h01);
    while (brst !== 1) @(negedge aclk);
    chk(16'(cyc - t1), 32);
    rc(4'h6, 8'h05);
    p80;
    rc(4'h6, 8'h04);
    wr(4'h7, 8'h00);
    wr(4'h9, 8'h00);
    // the line follows the mask one edge after the write lands
    @(negedge aclk);
    chk(irq, 0);
    wr(4'h6, 8'h05);
    rc(4'h6, 8'h00);
    wrap_up;
  end
endmodule
`default_nettype wire
